// >>> rtl/link_tx_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// RULE1 - Control codes: idle 00, hold 01, transmit 10, grant 11.
// RULE2 - Physical layer grants for one cycle, then one idle cycle.
// RULE3 - Physical layer tri-states its drivers after that idle cycle.
// RULE4 - Link drives at most one optional idle before hold or transmit.
// RULE5 - Link holds between zero and 47 cycles before transmit.
// RULE6 - Transmit code appears with the first packet data word.
// RULE7 - Transmit code stays until the last data word is driven.
// RULE8 - Packet end: hold or idle, one more idle, then release.
// RULE9 - Ending hold asks to keep the bus; ending idle releases it.
// RULE10 - Physical layer regrants after packet gap on concatenation.
// RULE11 - Without multispeed enable, one speed per bus ownership.
// RULE12 - With multispeed enable, next speed code sits on data during hold.
// RULE13 - Never concatenate a lowest-speed packet after a faster one.
// RULE14 - Physical layer drives idle one cycle after seeing release idle.
// RULE15 - One spare clock at each direction change of the lines.
// RULE16 - Physical layer idles at least once after regaining lines.
// RULE17 - Cancel: optional idle, up to 47 holds, two idles, release.
// RULE18 - Cancel without holds uses three consecutive idles.
// RULE19 - Concatenation speed codes share the receive speed encoding.
// RULE20 - Physical layer only samples the lines while the link owns them.
module link_tx_ctrl #(
	parameter int HOLD_LIMIT = link_tx_pkg::MAX_HOLD
) (
	// Clock, enable, reset
	input wire logic mclk,
	input wire logic ce,
	input wire logic rst_b,
	// Interface pins (two control and eight data lines each)
	input wire link_tx_pkg::pins_s pins_in,
	output link_tx_pkg::pins_s pins_out,
	output logic pins_oe_b,
	// Configuration
	input wire logic multispeed_concat_enable,
	input wire logic [link_tx_pkg::DATA_W-1:0] cur_speed,
	// Packet stream from the user
	input wire logic tx_valid,
	input wire logic [link_tx_pkg::DATA_W-1:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready,
	input wire link_tx_pkg::req_s req,
	// Status
	output logic owning,
	output logic done_pulse,
	output logic req_error
);
	import link_tx_pkg::*;

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	initial begin
		if (HOLD_LIMIT < 0 || HOLD_LIMIT > MAX_HOLD) begin
			$error("HOLD_LIMIT out of range");
		end
	end

	typedef enum logic [6:0] {
		ST_WAIT = 7'h01,
		ST_GRANTED = 7'h02,
		ST_HOLD = 7'h04,
		ST_XMIT = 7'h08,
		ST_END = 7'h10,
		ST_IDLE2 = 7'h20,
		ST_IDLE3 = 7'h40
	} state_e;

	state_e state_reg, state_next;
	logic [5:0] hold_cnt_reg, hold_cnt_next;
	logic [DATA_W-1:0] speed_reg, speed_next;
	logic concat_reg, concat_next;
	logic cancel_reg, cancel_next;
	logic no_hold_reg, no_hold_next;
	logic err_reg, err_next;
	pins_s drive_d;
	logic drive_en;
	logic [1:0] ctl_in;
	logic bad_speed;

	assign ctl_in = pins_in.ctl; // see RULE1
	// Lowest speed after a faster packet is refused for concatenation
	assign bad_speed = multispeed_concat_enable && (req.next_speed == SPD_LOWEST)
		&& (speed_reg != SPD_LOWEST); // see RULE13

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Grant is seen, then the physical layer's idle, then we own the lines
	always_comb begin
		state_next = state_reg;
		hold_cnt_next = hold_cnt_reg;
		speed_next = speed_reg;
		concat_next = concat_reg;
		cancel_next = cancel_reg;
		no_hold_next = no_hold_reg;
		err_next = 1'b0;
		drive_d.ctl = CODE_IDLE;
		drive_d.data = '0;
		drive_en = 1'b0;
		tx_ready = 1'b0;
		done_pulse = 1'b0;
		case (state_reg)
			ST_WAIT: begin
				// Lines are only sampled here; the pins still show the last idle on the first cycle
				if (ctl_in == CODE_GRANT) begin // see RULE2
					state_next = ST_GRANTED;
				end
			end
			ST_GRANTED: begin
				// Physical layer idle cycle; it tri-states after this one
				// so the spare turnaround clock passes before our first drive lands
				state_next = ST_HOLD; // see RULE3, RULE15
				hold_cnt_next = '0;
				cancel_next = req.cancel;
				no_hold_next = 1'b1;
				if (!multispeed_concat_enable && concat_reg) begin
					speed_next = speed_reg; // see RULE11
				end else if (!concat_reg) begin
					speed_next = cur_speed;
				end
			end
			ST_HOLD: begin
				// Registered drive: this value shows on the pins next cycle
				drive_en = 1'b1;
				if (cancel_reg || req.cancel) begin
					// Cancel: idle now, then two more idles without holds, one more after holds
					drive_d.ctl = CODE_IDLE;
					cancel_next = 1'b1;
					concat_next = 1'b0;
					state_next = no_hold_reg ? ST_IDLE3 : ST_IDLE2; // see RULE17, RULE18
				end else if (tx_valid) begin
					drive_d.ctl = CODE_XMIT; // see RULE6
					drive_d.data = tx_data;
					tx_ready = 1'b1;
					state_next = tx_last ? ST_END : ST_XMIT;
				end else if (hold_cnt_reg == 6'(HOLD_LIMIT)) begin
					// Hold budget spent: abandon as a cancel
					drive_d.ctl = CODE_IDLE;
					concat_next = 1'b0;
					state_next = ST_IDLE2; // see RULE5
				end else begin
					drive_d.ctl = CODE_HOLD; // see RULE4, RULE5
					hold_cnt_next = hold_cnt_reg + 6'h01;
					no_hold_next = 1'b0;
				end
			end
			ST_XMIT: begin
				drive_en = 1'b1;
				drive_d.ctl = CODE_XMIT; // see RULE7
				drive_d.data = tx_data;
				tx_ready = tx_valid;
				if (tx_valid && tx_last) begin
					state_next = ST_END;
				end else if (!tx_valid) begin
					// Underrun would corrupt the packet; flag it
					err_next = 1'b1;
					drive_d.data = '0;
				end
			end
			ST_END: begin
				drive_en = 1'b1;
				if (req.concat && !bad_speed) begin
					drive_d.ctl = CODE_HOLD; // see RULE8, RULE9
					drive_d.data = multispeed_concat_enable ? req.next_speed
						: '0; // see RULE12, RULE19
					concat_next = 1'b1;
					if (multispeed_concat_enable) begin
						speed_next = req.next_speed;
					end
				end else begin
					drive_d.ctl = CODE_IDLE; // see RULE9
					concat_next = 1'b0;
					err_next = req.concat;
				end
				state_next = ST_IDLE2;
			end
			ST_IDLE3: begin
				drive_en = 1'b1;
				drive_d.ctl = CODE_IDLE;
				state_next = ST_IDLE2;
			end
			ST_IDLE2: begin
				// Last idle before release; physical layer takes over after
				drive_en = 1'b1;
				drive_d.ctl = CODE_IDLE; // see RULE8, RULE17
				done_pulse = 1'b1;
				state_next = ST_WAIT; // see RULE10, RULE14, RULE16, RULE20
			end
			default: begin
				state_next = ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			state_reg <= ST_WAIT;
			hold_cnt_reg <= '0;
			speed_reg <= SPD_LOWEST;
			concat_reg <= 1'b0;
			cancel_reg <= 1'b0;
			no_hold_reg <= 1'b1;
			err_reg <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			hold_cnt_reg <= hold_cnt_next;
			speed_reg <= speed_next;
			concat_reg <= concat_next;
			cancel_reg <= cancel_next;
			no_hold_reg <= no_hold_next;
			err_reg <= err_next;
		end
	end

	// ----------------------------------------------------------------
	// Pin output register
	// ----------------------------------------------------------------
	logic en_q;
	link_tx_word_reg i_link_tx_word_reg (
		.mclk(mclk),
		.rst_b(rst_b),
		.ce(ce),
		.d(drive_d),
		.en_d(drive_en),
		.q(pins_out),
		.en_q(en_q)
	);

	assign pins_oe_b = ~en_q;
	assign owning = en_q;
	assign req_error = err_reg;

	// ----------------------------------------------------------------
	// Hold run counter, read only by the assertions
	// ----------------------------------------------------------------
	logic [5:0] hold_run_reg, hold_run_next;

	// Counts consecutive hold codes on the pins; saturates so a runaway cannot wrap to zero
	always_comb begin
		hold_run_next = '0;
		if (en_q && pins_out.ctl == CODE_HOLD) begin
			hold_run_next = (&hold_run_reg) ? hold_run_reg : hold_run_reg + 6'h01;
		end
	end

	// Frozen with the rest of the block while the enable is low
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			hold_run_reg <= '0;
		end else if (ce) begin
			hold_run_reg <= hold_run_next;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b || !ce);

	// Handover: two quiet clocks after grant, then our first drive
	grant_then_own_a: assert property (state_reg == ST_WAIT // see RULE3
		&& ctl_in == CODE_GRANT |=> ##1 drive_en)
		else $error("no drive after grant");
	turn_gap_a: assert property (state_reg == ST_WAIT // see RULE15
		&& ctl_in == CODE_GRANT |=> !en_q ##1 !en_q ##1 en_q)
		else $error("turnaround not kept");
	wait_quiet_a: assert property (state_reg == ST_WAIT // see RULE15
		&& $past(state_reg) == ST_WAIT |-> !en_q)
		else $error("drive while not owning");

	// Before data: one idle at most, and the hold budget seen on the pins
	lone_idle_a: assert property ((en_q && pins_out.ctl == CODE_IDLE) ##1 // see RULE4
		(en_q && pins_out.ctl == CODE_IDLE) |=> !en_q || pins_out.ctl == CODE_IDLE)
		else $error("idle before data");
	hold_bound_a: assert property (hold_run_reg <= 6'(HOLD_LIMIT)) // see RULE5
		else $error("hold too long");

	// Packet body and its end
	xmit_data_a: assert property (tx_ready && tx_valid |=> en_q // see RULE6
		&& pins_out.ctl == CODE_XMIT && pins_out.data == $past(tx_data))
		else $error("data not with transmit");
	xmit_cont_a: assert property (state_reg == ST_XMIT |=> en_q // see RULE7
		&& pins_out.ctl == CODE_XMIT) else $error("transmit dropped");
	end_idle_a: assert property (state_reg == ST_END |=> ##1 // see RULE8
		(en_q && pins_out.ctl == CODE_IDLE) ##1 !en_q)
		else $error("bad packet end");
	speed_code_a: assert property (state_reg == ST_IDLE2 && en_q // see RULE12
		&& pins_out.ctl == CODE_HOLD && multispeed_concat_enable
		|-> pins_out.data == speed_reg) else $error("speed code missing");
	no_slow_a: assert property (state_reg == ST_IDLE2 && en_q // see RULE13
		&& pins_out.ctl == CODE_HOLD && multispeed_concat_enable
		|-> !(pins_out.data == SPD_LOWEST && $past(speed_reg) != SPD_LOWEST))
		else $error("slow concatenation");

	// Cancel endings: three idles without holds, two after holds
	cancel_idles_a: assert property (state_reg == ST_IDLE3 |-> // see RULE18
		(en_q && pins_out.ctl == CODE_IDLE) ##1 (en_q && pins_out.ctl == CODE_IDLE)
		##1 (en_q && pins_out.ctl == CODE_IDLE) ##1 !en_q)
		else $error("cancel idles wrong");
	cancel_pair_a: assert property (state_reg == ST_HOLD // see RULE17
		&& drive_d.ctl == CODE_IDLE && !no_hold_reg |=> (en_q && pins_out.ctl == CODE_IDLE)
		##1 (en_q && pins_out.ctl == CODE_IDLE) ##1 !en_q)
		else $error("cancel release wrong");

	// Main scenarios reached
	normal_c: cover property (state_reg == ST_XMIT ##[1:20] state_reg == ST_END);
	concat_c: cover property (state_reg == ST_END && drive_d.ctl == CODE_HOLD);
	cancel_c: cover property (state_reg == ST_IDLE3);
	hold_c: cover property (state_reg == ST_HOLD && hold_cnt_reg == 6'h03);
	overrun_c: cover property (state_reg == ST_HOLD && hold_cnt_reg == 6'(HOLD_LIMIT) && !tx_valid);
endmodule

// >>> rtl/link_tx_pkg.sv
package link_tx_pkg;

	// ----------------------------------------------------------------
	// Control line codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CODE_IDLE = 2'h0;
	localparam logic [1:0] CODE_HOLD = 2'h1;
	localparam logic [1:0] CODE_XMIT = 2'h2;
	localparam logic [1:0] CODE_GRANT = 2'h3;

	// ----------------------------------------------------------------
	// Timing limits in interface clocks
	// ----------------------------------------------------------------
	localparam int MAX_HOLD = 47;
	localparam int END_IDLES = 2;
	localparam int CANCEL_IDLES = 3;

	// ----------------------------------------------------------------
	// Data line width and speed code defaults
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam logic [DATA_W-1:0] SPD_LOWEST = 8'h00;

	// Pin group towards the physical layer
	typedef struct packed {
		logic [1:0] ctl;
		logic [DATA_W-1:0] data;
	} pins_s;

	// User-side request
	typedef struct packed {
		logic cancel;
		logic concat;
		logic [DATA_W-1:0] next_speed;
	} req_s;

endpackage

// >>> rtl/link_tx_word_reg.sv
`timescale 1ns/1ps
// Output register for the pin group; data outputs come from flip-flops
module link_tx_word_reg (
	// Clock and control
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic ce,
	// Data
	input wire link_tx_pkg::pins_s d,
	input wire logic en_d,
	output link_tx_pkg::pins_s q,
	output logic en_q
);
	import link_tx_pkg::*;

	pins_s q_reg;
	logic en_reg;

	// Registered pin copy, idle and released after reset
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			q_reg <= '0;
			en_reg <= 1'b0;
		end else if (ce) begin
			q_reg <= d;
			en_reg <= en_d;
		end
	end

	assign q = q_reg;
	assign en_q = en_reg;
endmodule

// >>> dv/phy_dev_model.sv
`timescale 1ns/1ps
// Behavioural physical layer: grants the lines, watches the link, takes them back
module phy_dev_model #(
	parameter int GAP = 4
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// Bench request and resolved lines
	input wire logic start,
	input wire link_tx_pkg::pins_s lines,
	input wire logic link_oe_b,
	// Drive towards the lines
	output link_tx_pkg::pins_s drv,
	output logic drv_oe_b,
	output logic busy
);
	import link_tx_pkg::*;
	typedef enum logic [2:0] {S_IDLE, S_GNT, S_GID, S_LINK, S_GAP} st_e;
	st_e st = S_IDLE;
	logic [1:0] p1 = '0;
	logic [1:0] p2 = '0;
	logic seen = 1'b0;
	logic again = 1'b0;
	int cnt = 0;
	// Grant for one cycle, idle for one, then let go and only watch
	assign drv.ctl = (st == S_GNT) ? CODE_GRANT : CODE_IDLE;
	assign drv.data = '0;
	assign drv_oe_b = (st == S_LINK);
	assign busy = (st != S_IDLE);
	// The link's release is seen a cycle late, which leaves the spare turnaround clock
	always @(posedge mclk) begin
		if (!rst_b) begin
			st <= S_IDLE;
		end else begin
			case (st)
				S_IDLE: if (start) st <= S_GNT;
				S_GNT: st <= S_GID;
				S_GID: begin
					st <= S_LINK;
					seen <= 1'b0;
				end
				S_LINK: if (!link_oe_b) begin
					seen <= 1'b1;
					p1 <= lines.ctl;
					p2 <= p1;
				end else if (seen) begin
					st <= S_GAP;
					again <= (p2 == CODE_HOLD);
					cnt <= (p2 == CODE_HOLD) ? GAP : 1;
				end
				default: begin
					cnt <= cnt - 1;
					if (cnt == 1) st <= again ? S_GNT : S_IDLE;
				end
			endcase
		end
	end
endmodule

// >>> dv/link_tx_ctrl_bench.sv
`timescale 1ns/1ps
module link_tx_ctrl_bench;
	import link_tx_pkg::*;
	logic mclk = 0, rst_b = 0, ms = 0, tx_valid = 0, tx_last = 0, start = 0, flip = 0;
	logic [7:0] cur = 8'h01, tx_data = 8'h00, td;
	logic [1:0] tc;
	req_s req = '0;
	pins_s lines, last = '0, pins_out, phy_drv, e;
	logic pins_oe_b, phy_oe_b, busy, tx_ready, owning, done_pulse, req_error;
	logic was_x = 0;
	pins_s q[$];
	int miscompares = 0, total_checks = 0, run = 0, idles = 0, dones = 0, errs = 0;
	int n1, n2, exp_run;
	// Hold budget given to the design; the overrun test expects exactly this many holds
	localparam int HOLDS = 3;

	// A released line shows a changing pattern, never its old value
	assign lines = !pins_oe_b ? pins_out : !phy_oe_b ? phy_drv :
		{(flip ? 2'h1 : 2'h2), ~last.data};
	always #25 mclk = ~mclk;

	link_tx_ctrl #(.HOLD_LIMIT(HOLDS)) i_link_tx_ctrl (.mclk(mclk), .ce(1'b1), .rst_b(rst_b),
		.pins_in(lines), .pins_out(pins_out), .pins_oe_b(pins_oe_b),
		.multispeed_concat_enable(ms), .cur_speed(cur), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .req(req),
		.owning(owning), .done_pulse(done_pulse), .req_error(req_error));
	phy_dev_model i_phy_dev_model (.mclk(mclk), .rst_b(rst_b), .start(start),
		.lines(lines), .link_oe_b(pins_oe_b), .drv(phy_drv), .drv_oe_b(phy_oe_b),
		.busy(busy));

	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Bounded wait until the link lets go (and the far side is idle unless told otherwise)
	task automatic quiet(logic link_only);
		int k;
		for (k = 0; k < 300; k++) begin
			@(posedge mclk);
			#1;
			if (owning === 1'b0 && (link_only || busy === 1'b0)) break;
		end
		if (k == 300) begin
			miscompares++;
			complete_run();
		end
	endtask

	// Hand words over one at a time, noting each as an expected transmit cycle
	task automatic feed(int n);
		int k;
		for (int i = 0; i < n; i++) begin
			tx_valid = 1;
			tx_data = 8'($urandom);
			tx_last = (i == n - 1);
			q.push_back({CODE_XMIT, tx_data});
			for (k = 0; k < 300; k++) begin
				@(negedge mclk);
				if (tx_ready === 1'b1) break;
			end
			@(posedge mclk);
			#1;
			if (k == 300) begin
				miscompares++;
				complete_run();
			end
		end
		tx_valid = 0;
		tx_last = 0;
	endtask

	// Compare each driven transmit word and the code that closes the packet
	always @(posedge mclk) begin
		flip <= ~flip;
		last <= lines;
		if (rst_b && pins_oe_b === 1'b0) begin
			run++;
			if (pins_out.ctl === CODE_IDLE) idles++;
			if (pins_out.ctl === CODE_XMIT || was_x) begin
				e = (q.size() > 0) ? q.pop_front() : 10'h3ff;
				chk("ctl", 8'(e.ctl), 8'(pins_out.ctl));
				if (e.ctl !== CODE_IDLE) chk("data", e.data, pins_out.data);
			end
			was_x = (pins_out.ctl === CODE_XMIT);
		end
		if (done_pulse === 1'b1) dones++;
		if (req_error === 1'b1) errs++;
	end

	// Plain, concatenated at one and at a new speed, refused slow, cancel, hold overrun
	initial begin
		void'($urandom(32'hbda222da));
		repeat (8) @(posedge mclk);
		#1 rst_b = 1;
		for (int t = 0; t < 6; t++) begin
			n1 = (t < 4) ? 1 + $urandom % 8 : 0;
			n2 = (t == 1 || t == 2) ? 1 + $urandom % 8 : 0;
			ms = (t >= 2);
			cur = (t == 3) ? 8'h02 : 8'h01;
			req = '{cancel: (t == 4), concat: (t >= 1 && t <= 3),
				next_speed: (t == 3) ? SPD_LOWEST : 8'h02};
			tc = (n2 > 0) ? CODE_HOLD : CODE_IDLE;
			td = (t == 2) ? 8'h02 : 8'h00;
			run = 0;
			idles = 0;
			dones = 0;
			errs = 0;
			start = 1;
			@(posedge mclk);
			#1 start = 0;
			feed(n1);
			if (n1 > 0) q.push_back({tc, td});
			if (n2 > 0) begin
				quiet(1'b1);
				req.concat = 0;
				feed(n2);
				q.push_back({CODE_IDLE, 8'h00});
			end
			quiet(1'b0);
			exp_run = (t == 4) ? CANCEL_IDLES : (t == 5) ? HOLDS + END_IDLES :
				n1 + n2 + END_IDLES * ((n2 > 0) ? 2 : 1);
			chk("run", 8'(exp_run), 8'(run));
			chk("idles", 8'((t == 4 || n2 > 0) ? 3 : 2), 8'(idles));
			chk("dones", 8'((n2 > 0) ? 2 : 1), 8'(dones));
			chk("errs", 8'(t == 3), 8'(errs));
			chk("left", 8'h00, 8'(q.size()));
			$display("test %0d finished", t);
		end
		complete_run();
	end
endmodule
